/* hw/asptx_top.sv */
/*
 * Asynchronous serial port: baud divisor, autobaud lock, transmitter with
 * holding and shift registers, receiver with receive FIFO, four auxiliary
 * pins with change detection, and the merged serial interrupt.
 * Assumes CPU I/O-space strobes on clk, a remote host on rx_pin/tx_pin.
 */
// Functional notes
// - Divisor zero stops all transmit and receive.
// - Reset loads the baud divisor with one.
// - A bit lasts sixteen times divisor clock cycles.
// - Armed, a received A or a locks the rate into the divisor.
// - Autobaud lock raises the serial interrupt only while autobaud enable is set.
// - Host reads the lock character; else next character flags overrun.
// - Enabled autobaud keeps relocking; enable plus done keeps interrupting.
// - Direction bit one makes an aux pin an output; reset clears all.
// - Status bits 3..0 read input aux pin levels, and the driven level for output pins.
// - Input pin change sets its flag and requests interrupt; one clears.
// - Change detection only for input pins while port runs.
// - Writing status low bits drives output aux pins.
// - Empty holding register sets flag, interrupts while empty, when enabled.
// - Ready, overrun, framing, break interrupt under receive enable.
// - Pin changes interrupt only with delta enable set.
// - All sources merge onto one serial interrupt line.
// - Write loads holding register; write when both full is ignored.
// - Holding-empty clears on load; all-empty needs both registers empty.
// - Frame: start, eight data bits LSB first, one or two stops.
// - Idle TX line stays high while force break is clear.
// - Receiver takes falling edge, validates start unless autobaud is enabled, shifts LSB first.
// - Ready clears on buffer read; error flags clear by writing one.
`timescale 1ns/1ps
`default_nettype none
module asptx_top
  import asptx_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr_en,
  input  wire logic        io_rd_en,
  input  wire logic [15:0] io_wdata,
  output logic      [15:0] io_rdata,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  input  wire logic [3:0]  aux_pin_in,
  output logic      [3:0]  aux_pin_out,
  output logic      [3:0]  aux_pin_oe,
  output logic             serial_irq
);

  typedef struct packed {
    logic [15:0] div;
    logic [15:0] ctrl;
    logic [15:0] rdata;
    logic        adc;
    logic        brk;
    logic        fe;
    logic        oe;
    logic        dr;
    logic [3:0]  chg;
    logic [3:0]  aux_out;
    logic [3:0]  aux_prev;
    logic [7:0]  cbuf;
    asptx_tx_e   tx_st;
    logic        hold_full;
    logic [7:0]  hold;
    logic [7:0]  tx_shift;
    logic [2:0]  tx_bit;
    logic        tx_stop2;
    logic [19:0] tx_cnt;
    logic        tx_line;
    asptx_rx_e   rx_st;
    logic [7:0]  rx_shift;
    logic [2:0]  rx_bit;
    logic [19:0] rx_cnt;
    logic [15:0] cand;
    logic        rx_ab;
    logic        rx_prev;
    logic        irq;
  } asptx_top_s;

  asptx_top_s  s_reg;
  asptx_top_s  s_next;

  logic        rx_lvl;
  logic [3:0]  aux_lvl;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_pop;
  logic        rx_push;
  logic [7:0]  rx_push_data;
  logic        wr_cbuf;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_div;
  logic        rd_cbuf;
  logic        div_zero;
  logic [15:0] rx_div;
  logic [19:0] tx_full;
  logic [19:0] rx_half;
  logic [19:0] rx_full;
  logic        rx_fall;
  logic        tx_all_empty;
  logic [3:0]  lvl_view;
  logic [15:0] stat_val;
  logic [15:0] w1c;
  logic        set_adc;
  logic        set_brk;
  logic        set_fe;
  logic        set_oe;
  logic [3:0]  set_chg;

  // ******************************************************************
  // Pin synchronisers and receive FIFO
  // ******************************************************************
  asptx_sync #(.WIDTH(1), .RESET_LEVEL(1'b1)) u_rx_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .async_in  (rx_pin),
    .level_out (rx_lvl)
  );

  asptx_sync #(.WIDTH(4), .RESET_LEVEL(4'h0)) u_aux_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .async_in  (aux_pin_in),
    .level_out (aux_lvl)
  );

  // The FIFO drains into char_buffer only while it is empty, so a slow
  // reader stalls the FIFO; when it fills, new characters are dropped.
  asptx_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (rx_push),
    .in_data   (rx_push_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (!s_reg.dr)
  );

  // ******************************************************************
  // Decode and derived values
  // ******************************************************************
  assign wr_cbuf  = io_wr_en && (io_addr == ADDR_CHAR_BUF);
  assign wr_ctrl  = io_wr_en && (io_addr == ADDR_PORT_CTRL);
  assign wr_stat  = io_wr_en && (io_addr == ADDR_LINE_STAT);
  assign wr_div   = io_wr_en && (io_addr == ADDR_BAUD_DIV);
  assign rd_cbuf  = io_rd_en && (io_addr == ADDR_CHAR_BUF);
  assign fifo_pop = fifo_out_valid && !s_reg.dr;
  assign div_zero = s_reg.div == 16'h0000;
  assign rx_div   = s_reg.rx_ab ? s_reg.cand : s_reg.div;
  assign tx_full  = {s_reg.div, 4'h0} - 20'h00001;
  assign rx_half  = {1'b0, rx_div, 3'h0} - 20'h00001;
  assign rx_full  = {rx_div, 4'h0} - 20'h00001;
  assign rx_fall  = s_reg.rx_prev && !rx_lvl;
  assign tx_all_empty     = !s_reg.hold_full && (s_reg.tx_st == TX_IDLE);
  assign lvl_view = (s_reg.ctrl[3:0] & s_reg.aux_out) | (~s_reg.ctrl[3:0] & aux_lvl);
  assign stat_val = {1'b0, s_reg.adc, s_reg.brk, tx_all_empty, !s_reg.hold_full, s_reg.fe,
                     s_reg.oe, s_reg.dr, s_reg.chg, lvl_view};
  assign w1c      = wr_stat ? io_wdata : 16'h0000;

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    s_next       = s_reg;
    rx_push      = 1'b0;
    rx_push_data = s_reg.rx_shift;
    set_adc      = 1'b0;
    set_brk      = 1'b0;
    set_fe       = 1'b0;
    set_oe       = 1'b0;

    // Transmitter
    s_next.tx_cnt = s_reg.tx_cnt + 20'h00001;
    case (s_reg.tx_st)
      TX_IDLE: begin
        s_next.tx_cnt = '0;
        if (s_reg.hold_full && !div_zero) begin
          s_next.tx_shift  = s_reg.hold;
          s_next.hold_full = 1'b0;
          s_next.tx_st     = TX_START;
        end
      end
      TX_START: begin
        if (s_reg.tx_cnt >= tx_full) begin
          s_next.tx_cnt = '0;
          s_next.tx_bit = '0;
          s_next.tx_st  = TX_DATA;
        end
      end
      TX_DATA: begin
        if (s_reg.tx_cnt >= tx_full) begin
          s_next.tx_cnt   = '0;
          s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
          if (s_reg.tx_bit == 3'h7) begin
            s_next.tx_stop2 = s_reg.ctrl[CTL_STB];
            s_next.tx_st    = TX_STOP;
          end else begin
            s_next.tx_bit = s_reg.tx_bit + 3'h1;
          end
        end
      end
      TX_STOP: begin
        if (s_reg.tx_cnt >= tx_full) begin
          s_next.tx_cnt = '0;
          if (s_reg.tx_stop2) begin
            s_next.tx_stop2 = 1'b0;
          end else begin
            s_next.tx_st = TX_IDLE;
          end
        end
      end
      default: s_next.tx_st = TX_IDLE;
    endcase
    if (div_zero) begin
      s_next.tx_st = TX_IDLE;
    end
    // A write while holding and shift registers are both busy is dropped
    if (wr_cbuf && !s_next.hold_full) begin
      s_next.hold      = io_wdata[7:0];
      s_next.hold_full = 1'b1;
    end

    // Receiver
    s_next.rx_prev = rx_lvl;
    s_next.rx_cnt  = s_reg.rx_cnt + 20'h00001;
    case (s_reg.rx_st)
      RX_IDLE: begin
        s_next.rx_cnt = 20'h00001;
        if (rx_fall && !div_zero) begin
          s_next.rx_ab = s_reg.ctrl[CTL_CAD];
          s_next.rx_st = s_reg.ctrl[CTL_CAD] ? RX_MEASURE : RX_START;
        end
      end
      RX_MEASURE: begin
        // Start bit of A or a is followed by a one, so its width is one bit time
        if (rx_lvl) begin
          s_next.cand   = (s_reg.rx_cnt[19:4] == 16'h0000) ? 16'h0001 : s_reg.rx_cnt[19:4];
          s_next.rx_cnt = '0;
          s_next.rx_bit = '0;
          s_next.rx_st  = RX_DATA;
        end else if (&s_reg.rx_cnt) begin
          s_next.rx_st = RX_IDLE;
        end
      end
      RX_START: begin
        if ((s_reg.rx_cnt == rx_half) && rx_lvl) begin
          s_next.rx_st = RX_IDLE;
        end else if (s_reg.rx_cnt >= rx_full) begin
          s_next.rx_cnt = '0;
          s_next.rx_bit = '0;
          s_next.rx_st  = RX_DATA;
        end
      end
      RX_DATA: begin
        if (s_reg.rx_cnt == rx_half) begin
          s_next.rx_shift = {rx_lvl, s_reg.rx_shift[7:1]};
        end
        if (s_reg.rx_cnt >= rx_full) begin
          s_next.rx_cnt = '0;
          if (s_reg.rx_bit == 3'h7) begin
            s_next.rx_st = RX_STOP;
          end else begin
            s_next.rx_bit = s_reg.rx_bit + 3'h1;
          end
        end
      end
      RX_STOP: begin
        // Only the first stop bit is checked; leaving early keeps the
        // receiver ready for a start bit right after a short stop.
        if (s_reg.rx_cnt == rx_half) begin
          s_next.rx_st = RX_IDLE;
          if (rx_lvl) begin
            rx_push = 1'b1;
            set_oe  = s_reg.dr || !fifo_in_ready;
            if (s_reg.rx_ab && ((s_reg.rx_shift == AUTOBAUD_UPPER) ||
                                (s_reg.rx_shift == AUTOBAUD_LOWER))) begin
              s_next.div = s_reg.cand;
              set_adc    = 1'b1;
            end
          end else begin
            set_fe  = 1'b1;
            set_brk = s_reg.rx_shift == 8'h00;
          end
        end
      end
      default: s_next.rx_st = RX_IDLE;
    endcase
    if (div_zero) begin
      s_next.rx_st = RX_IDLE;
    end

    // Receive buffer: a pop in the cycle of a read keeps ready set
    if (fifo_pop) begin
      s_next.cbuf = fifo_out_data;
      s_next.dr   = 1'b1;
    end else if (rd_cbuf) begin
      s_next.dr = 1'b0;
    end

    // Aux pins
    set_chg         = ~s_reg.ctrl[3:0] & (aux_lvl ^ s_reg.aux_prev)
                      & {4{s_reg.ctrl[CTL_RUN]}};
    s_next.aux_prev = aux_lvl;
    s_next.chg      = set_chg | (s_reg.chg & ~w1c[7:4]);
    if (wr_stat) begin
      s_next.aux_out = (s_reg.ctrl[3:0] & io_wdata[3:0])
                       | (~s_reg.ctrl[3:0] & s_reg.aux_out);
    end

    // Sticky flags: a set in the cycle of a clear wins
    s_next.adc = set_adc | (s_reg.adc & ~w1c[ST_ADC]);
    s_next.brk = set_brk | (s_reg.brk & ~w1c[ST_BI]);
    s_next.fe  = set_fe | (s_reg.fe & ~w1c[ST_FE]);
    s_next.oe  = set_oe | (s_reg.oe & ~w1c[ST_OE]);

    // Register writes; an autobaud lock in the same cycle overrides
    if (wr_ctrl) begin
      s_next.ctrl = io_wdata;
    end
    if (wr_div && !set_adc) begin
      s_next.div = io_wdata;
    end

    // Register reads
    if (io_rd_en) begin
      if (io_addr == ADDR_CHAR_BUF) begin
        s_next.rdata = {8'h00, s_reg.cbuf};
      end else if (io_addr == ADDR_PORT_CTRL) begin
        s_next.rdata = s_reg.ctrl;
      end else if (io_addr == ADDR_LINE_STAT) begin
        s_next.rdata = stat_val;
      end else if (io_addr == ADDR_BAUD_DIV) begin
        s_next.rdata = s_reg.div;
      end else begin
        s_next.rdata = 16'h0000;
      end
    end

    // Line drive follows the next transmit state
    if (s_next.ctrl[CTL_BRK]) begin
      s_next.tx_line = 1'b0;
    end else if (s_next.tx_st == TX_START) begin
      s_next.tx_line = 1'b0;
    end else if (s_next.tx_st == TX_DATA) begin
      s_next.tx_line = s_next.tx_shift[0];
    end else begin
      s_next.tx_line = 1'b1;
    end

    // Merged interrupt, level while any enabled source stands
    s_next.irq = (s_reg.ctrl[CTL_RIE] & (s_reg.dr | s_reg.oe | s_reg.fe | s_reg.brk))
               | (s_reg.ctrl[CTL_TIE] & !s_reg.hold_full)
               | (s_reg.ctrl[CTL_DIE] & (|s_reg.chg))
               | (s_reg.ctrl[CTL_CAD] & s_reg.adc);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg         <= '0;
      s_reg.div     <= BAUD_DIV_RESET;
      s_reg.ctrl    <= PORT_CTRL_RESET;
      s_reg.tx_line <= 1'b1;
      s_reg.rx_prev <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign io_rdata    = s_reg.rdata;
  assign tx_pin      = s_reg.tx_line;
  assign aux_pin_out = s_reg.aux_out;
  assign aux_pin_oe  = s_reg.ctrl[3:0];
  assign serial_irq  = s_reg.irq;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_ZERO_DIV_NO_TX: assert property (div_zero |=> s_reg.tx_st == TX_IDLE)
    else $error("transmitter active with zero divisor");
  AST_ZERO_DIV_NO_RX: assert property (div_zero |=> s_reg.rx_st == RX_IDLE)
    else $error("receiver active with zero divisor");
  AST_IDLE_HIGH: assert property ((s_reg.tx_st == TX_IDLE) && !s_reg.ctrl[CTL_BRK] |-> tx_pin)
    else $error("idle line not high");
  AST_START_LOW: assert property (s_reg.tx_st == TX_START |-> !tx_pin)
    else $error("start bit not low");
  AST_TX_IRQ: assert property (s_reg.ctrl[CTL_TIE] && !s_reg.hold_full |=> serial_irq)
    else $error("transmit interrupt missing");
  AST_AUTOBAUD_IRQ: assert property (s_reg.ctrl[CTL_CAD] && s_reg.adc |=> serial_irq)
    else $error("autobaud interrupt missing");
  // The shifter keeps moving during a dropped write; only the held byte and its full flag must stay
  AST_HOLD_KEEP: assert property (wr_cbuf && s_reg.hold_full && (s_reg.tx_st != TX_IDLE)
                                  |=> $stable(s_reg.hold) && s_reg.hold_full)
    else $error("write while full altered data");
  AST_AUX_DRIVE: assert property (wr_stat && s_reg.ctrl[0] && !wr_ctrl
                                  |=> aux_pin_out[0] == $past(io_wdata[0]))
    else $error("output pin did not take written level");
  AST_NO_CHG_STOPPED: assert property (!s_reg.ctrl[CTL_RUN] && s_reg.chg == 4'h0
                                       |=> s_reg.chg == 4'h0)
    else $error("change flag set while port stopped");
  AST_TX_ALL_EMPTY_READ: assert property (io_rd_en && (io_addr == ADDR_LINE_STAT)
                                  |=> io_rdata[ST_TX_ALL_EMPTY] == $past(tx_all_empty))
    else $error("all-empty bit wrong");
  AST_DR_CLEAR: assert property (rd_cbuf && s_reg.dr && !fifo_out_valid ##1 !fifo_pop
                                 |-> !s_reg.dr)
    else $error("ready flag not cleared by read");
  // The bit counter itself bounds the bit: it may never pass 15 at divisor one
  AST_BIT_TIME: assert property ((s_reg.tx_st == TX_DATA) && (s_reg.div == 16'h0001)
                                 && $stable(s_reg.div) |-> s_reg.tx_cnt <= 20'h0000f)
    else $error("bit time longer than sixteen cycles");

  COV_AUTOBAUD_LOCK: cover property (set_adc);
  COV_FRAMING: cover property (set_fe);
  COV_TWO_STOP: cover property (s_reg.tx_st == TX_STOP && s_reg.tx_stop2);
  COV_FIFO_FULL: cover property (!fifo_in_ready);

endmodule
`default_nettype wire

/* include/asptx_pkg.sv */
/*
 * Shared constants for the asynchronous serial port: I/O-space offsets,
 * control and status bit positions, reset values and state encodings.
 * Assumes a 16-bit CPU I/O space with one register per address.
 */
package asptx_pkg;

  // ******************************************************************
  // Register offsets in I/O space
  // ******************************************************************
  localparam logic [15:0] ADDR_CHAR_BUF  = 16'hfff4;
  localparam logic [15:0] ADDR_PORT_CTRL = 16'hfff5;
  localparam logic [15:0] ADDR_LINE_STAT = 16'hfff6;
  localparam logic [15:0] ADDR_BAUD_DIV  = 16'hfff7;

  // ******************************************************************
  // Reset values
  // ******************************************************************
  localparam logic [15:0] BAUD_DIV_RESET  = 16'h0001;
  localparam logic [15:0] PORT_CTRL_RESET = 16'h0000;

  // ******************************************************************
  // port_control_reg fields (bits 3..0 are aux_pin_direction)
  // ******************************************************************
  localparam int CTL_BRK = 4;   // force_break
  localparam int CTL_STB = 5;   // stop_bits_select, 1 = two stop bits
  localparam int CTL_CAD = 6;   // autobaud_enable
  localparam int CTL_DIE = 7;   // delta_irq_enable
  localparam int CTL_RIE = 8;   // rx_irq_enable
  localparam int CTL_TIE = 9;   // tx_irq_enable
  localparam int CTL_RUN = 13;  // port_run

  // ******************************************************************
  // line_status_reg fields
  // ******************************************************************
  localparam int ST_ADC  = 14;
  localparam int ST_BI   = 13;
  localparam int ST_TX_ALL_EMPTY = 12;
  localparam int ST_TX_HOLDING_EMPTY = 11;
  localparam int ST_FE   = 10;
  localparam int ST_OE   = 9;
  localparam int ST_DR   = 8;

  // ******************************************************************
  // Framing and buffering
  // ******************************************************************
  localparam int          OVERSAMPLE    = 16;
  localparam int          DATA_BITS     = 8;
  localparam int          RX_FIFO_DEPTH = 16;
  localparam logic [7:0]  AUTOBAUD_UPPER = 8'h41;
  localparam logic [7:0]  AUTOBAUD_LOWER = 8'h61;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} asptx_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_MEASURE, RX_START, RX_DATA, RX_STOP} asptx_rx_e;

endpackage

/* hw/asptx_sync.sv */
/*
 * Three-flop synchroniser for asynchronous pin inputs with agreement
 * filter: the output follows only once the second and third flops agree.
 * Assumes inputs are unrelated to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module asptx_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_LEVEL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] lvl;
  } asptx_sync_s;

  asptx_sync_s s_reg;
  asptx_sync_s s_next;

  always_comb begin
    s_next     = s_reg;
    s_next.ff1 = async_in;
    s_next.ff2 = s_reg.ff1;
    s_next.ff3 = s_reg.ff2;
    // ff1 feeds only ff2; the filter looks at ff2 and ff3
    s_next.lvl = (~(s_reg.ff2 ^ s_reg.ff3) & s_reg.ff3) | ((s_reg.ff2 ^ s_reg.ff3) & s_reg.lvl);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= {RESET_LEVEL, RESET_LEVEL, RESET_LEVEL, RESET_LEVEL};
    end else begin
      s_reg <= s_next;
    end
  end

  assign level_out = s_reg.lvl;

endmodule
`default_nettype wire

/* hw/asptx_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock; push and pop may occur in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module asptx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } asptx_fifo_s;

  asptx_fifo_s s_reg;
  asptx_fifo_s s_next;
  logic        push;
  logic        pop;

  assign in_ready  = s_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_reg.cnt != '0;
  assign out_data  = s_reg.mem[s_reg.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data;
      s_next.wp = (s_reg.wp == AW'(DEPTH-1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == AW'(DEPTH-1)) ? '0 : s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule
`default_nettype wire

/* testbench/asptx_host.sv */
/* Remote serial host model: drives the receive line of the port.
   Assumes a 40 ns bench clock when converting cycles to time. */
`timescale 1ns/1ps
`default_nettype none
module asptx_host (
  output logic rx_pin
);
  initial rx_pin = 1'b1;
  // One stop bit only; the line rests high between frames
  task automatic send(input logic [7:0] b, input int cyc);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin = f[i];
      #(cyc * 40);
    end
  endtask
endmodule
`default_nettype wire

/* testbench/asptx_top_tb_top.sv */
/* Self-checking bench for the serial port top.
   Assumes the host model drives rx while the bench plays the CPU. */
`timescale 1ns/1ps
`default_nettype none
module asptx_top_tb_top import asptx_pkg::*;;
  logic        clk, rst_n, io_wr_en, io_rd_en, tx_pin, serial_irq, rx_pin;
  logic [15:0] io_addr, io_wdata, io_rdata, v;
  logic [3:0]  aux_pin_in, aux_pin_out, aux_pin_oe;
  logic [7:0]  b;
  int          failures = 0, total_checks = 0, cyc = 0, seed = 15;
  asptx_top asptx_top_inst (.clk(clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wr_en(io_wr_en), .io_rd_en(io_rd_en), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .aux_pin_in(aux_pin_in),
    .aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe), .serial_irq(serial_irq));
  asptx_host asptx_host_inst (.rx_pin(rx_pin));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Whole run needs well under two thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      summarize();
    end
  end
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk); io_addr = a; io_wdata = d; io_wr_en = 1'b1;
    @(negedge clk); io_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(negedge clk); io_addr = a; io_rd_en = 1'b1;
    @(negedge clk); io_rd_en = 1'b0;
    @(negedge clk); v = io_rdata;
  endtask
  function automatic logic [9:0] frame_of(input logic [7:0] d);
    return {1'b1, d, 1'b0};
  endfunction
  // Finds the start edge, then samples every bit at its middle; returns in
  // the middle of the first stop bit so that a queued frame is not missed
  task automatic tx_frame(input logic [7:0] d);
    logic [9:0] f;
    f = frame_of(d);
    for (int i = 0; i < 300 && tx_pin === 1'b1; i++) @(negedge clk);
    repeat (8) @(negedge clk);
    for (int i = 0; i < 10; i++) begin
      chk("tx_bit", {15'h0, f[i]}, {15'h0, tx_pin});
      if (i < 9) repeat (16) @(negedge clk);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0; io_addr = '0; io_wdata = '0; io_wr_en = 1'b0; io_rd_en = 1'b0;
    aux_pin_in = 4'h0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    rd(ADDR_BAUD_DIV);
    chk("divisor", BAUD_DIV_RESET, v);
    rd(ADDR_LINE_STAT);
    chk("status", 16'h1800, v);
    $display("reset test done");
    wr(ADDR_PORT_CTRL, 16'h2003);
    wr(ADDR_LINE_STAT, 16'h0005);
    chk("aux_oe", 16'h0003, {12'h0, aux_pin_oe});
    chk("aux_out", 16'h0001, {14'h0, aux_pin_out[1:0]});
    aux_pin_in = 4'h8;
    repeat (8) @(negedge clk);
    rd(ADDR_LINE_STAT);
    chk("status", 16'h1889, v);
    chk("irq", 16'h0, {15'h0, serial_irq});
    wr(ADDR_PORT_CTRL, 16'h2083);
    @(negedge clk);
    chk("irq", 16'h1, {15'h0, serial_irq});
    wr(ADDR_LINE_STAT, 16'h0081);
    rd(ADDR_LINE_STAT);
    chk("status", 16'h1809, v);
    $display("aux test done");
    wr(ADDR_PORT_CTRL, 16'h20a3);
    b = 8'($random(seed));
    v = {8'h0, 8'($random(seed))};
    wr(ADDR_CHAR_BUF, {8'h0, b});
    wr(ADDR_CHAR_BUF, v);
    wr(ADDR_CHAR_BUF, 16'h00ff);
    tx_frame(b);
    repeat (16) @(negedge clk);
    chk("tx_stop2", 16'h1, {15'h0, tx_pin});
    tx_frame(v[7:0]);
    repeat (40) @(negedge clk);
    rd(ADDR_LINE_STAT);
    chk("tx_empty", 16'h1800, v & 16'h1800);
    wr(ADDR_PORT_CTRL, 16'h22a3);
    @(negedge clk);
    chk("irq", 16'h1, {15'h0, serial_irq});
    $display("tx test done");
    b = 8'($random(seed));
    asptx_host_inst.send(b, 16);
    repeat (30) @(negedge clk);
    rd(ADDR_LINE_STAT);
    chk("rx_ready", 16'h0100, v & 16'h0100);
    rd(ADDR_CHAR_BUF);
    chk("rx_data", {8'h0, b}, v);
    rd(ADDR_LINE_STAT);
    chk("rx_ready", 16'h0, v & 16'h0100);
    $display("rx test done");
    wr(ADDR_BAUD_DIV, 16'h0);
    wr(ADDR_CHAR_BUF, 16'h0055);
    v = '0;
    repeat (100) begin
      @(negedge clk);
      v = v | {15'h0, ~tx_pin};
    end
    chk("tx_idle", 16'h0, v);
    wr(ADDR_BAUD_DIV, BAUD_DIV_RESET);
    tx_frame(8'h55);
    $display("divisor zero test done");
    wr(ADDR_PORT_CTRL, 16'h2040);
    asptx_host_inst.send(AUTOBAUD_UPPER, 32);
    repeat (30) @(negedge clk);
    chk("irq", 16'h1, {15'h0, serial_irq});
    rd(ADDR_BAUD_DIV);
    chk("divisor", 16'h0002, v);
    rd(ADDR_CHAR_BUF);
    chk("ab_char", {8'h0, AUTOBAUD_UPPER}, v);
    wr(ADDR_PORT_CTRL, 16'h2000);
    wr(ADDR_LINE_STAT, 16'h4000);
    rd(ADDR_LINE_STAT);
    chk("ab_flags", 16'h0, v & 16'h4100);
    chk("irq", 16'h0, {15'h0, serial_irq});
    $display("autobaud test done");
    summarize();
  end
endmodule
`default_nettype wire
